// ===== core/cpl_top.sv
`timescale 1ns/10ps
// ==========================================================
// Third routing register, port 0/1 latches and their pads
module cpl_top #(
   parameter int CAN_TX_PIN = 0,
   parameter int CMP2_PIN = 0,
   parameter int CONV2_START_PIN = 1,
   parameter int T3_CAPTURE_PIN = 2,
   parameter int T3_COUNT_PIN = 3
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Avalon-MM slave
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // On-chip peripherals
   input wire logic i_can_tx_route,
   input wire logic i_can_transmit_pin,
   input wire logic i_comparator2_output,
   output logic o_conv2_external_start,
   output logic o_timer3_capture_input,
   output logic o_timer3_count_input,
   // Port 0 pads
   input wire logic [7:0] i_p0_pad,
   output logic [7:0] o_p0_pad_out,
   output logic [7:0] o_p0_pad_oe,
   // Port 1 pads
   input wire logic [7:0] i_p1_pad,
   output logic [7:0] o_p1_pad_out,
   output logic [7:0] o_p1_pad_oe
);
   // ==========================================================
   // Elaboration checks
   if (CAN_TX_PIN > 7 || CMP2_PIN > 7 || CONV2_START_PIN > 7 ||
       T3_CAPTURE_PIN > 7 || T3_COUNT_PIN > 7) begin : g_bad_pin
      $error("Routed pin index must be 0 to 7");
   end

   // Single-bit mask at a pin index
   function automatic logic [7:0] pin_mask(input int idx);
      pin_mask = 8'h01 << idx[2:0];
   endfunction : pin_mask

   // ==========================================================
   // Register state
   logic [7:0] p0_latch_q, p0_latch_d;
   logic [7:0] p1_latch_q, p1_latch_d;
   logic [7:0] route3_q, route3_d;
   logic [7:0] p0_style_q, p0_style_d;
   logic [7:0] p1_style_q, p1_style_d;
   logic [7:0] p1_instyle_q, p1_instyle_d;
   logic wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d;
   logic conv2_q, conv2_d, t3cap_q, t3cap_d, t3cnt_q, t3cnt_d;
   logic [7:0] p0_level, p1_level;
   logic [7:0] p0_claim, p1_claim, p0_claim_val, p1_claim_val, p0_claim_pp, p1_claim_pp;
   logic wr_go, rd_go;
   logic [7:0] wbyte;

   // A request is served at the edge where waitrequest is seen low
   assign wr_go = i_avs_write && !wait_q;
   assign rd_go = i_avs_read && !wait_q;
   assign wbyte = i_avs_writedata[7:0];

   // ==========================================================
   // Register writes and bus handshake
   always_comb begin
      p0_latch_d = p0_latch_q;
      p1_latch_d = p1_latch_q;
      route3_d = route3_q;
      p0_style_d = p0_style_q;
      p1_style_d = p1_style_q;
      p1_instyle_d = p1_instyle_q;
      // One wait cycle, then a single low cycle to finish the transfer
      wait_d = !((i_avs_read || i_avs_write) && wait_q);
      if (wr_go && i_avs_byteenable[0]) begin
         unique case (i_avs_address)
            cpl_pkg::ADDR_PORT0_DATA, cpl_pkg::ADDR_PORT0_RMW: p0_latch_d = wbyte;
            cpl_pkg::ADDR_PORT1_DATA, cpl_pkg::ADDR_PORT1_RMW: p1_latch_d = wbyte;
            cpl_pkg::ADDR_ROUTE3: route3_d = wbyte & cpl_pkg::ROUTE3_WRITE_MASK;
            cpl_pkg::ADDR_PORT0_STYLE: p0_style_d = wbyte;
            cpl_pkg::ADDR_PORT1_STYLE: p1_style_d = wbyte;
            cpl_pkg::ADDR_PORT1_INSTYLE: p1_instyle_d = wbyte;
            default: ; // Unmapped writes are dropped
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         p0_latch_q <= cpl_pkg::RST_PORT_LATCH;
         p1_latch_q <= cpl_pkg::RST_PORT_LATCH;
         route3_q <= cpl_pkg::RST_ROUTE3;
         p0_style_q <= cpl_pkg::RST_OUT_STYLE;
         p1_style_q <= cpl_pkg::RST_OUT_STYLE;
         p1_instyle_q <= cpl_pkg::RST_IN_STYLE;
         wait_q <= 1'b1;
      end else begin
         p0_latch_q <= p0_latch_d;
         p1_latch_q <= p1_latch_d;
         route3_q <= route3_d;
         p0_style_q <= p0_style_d;
         p1_style_q <= p1_style_d;
         p1_instyle_q <= p1_instyle_d;
         wait_q <= wait_d;
      end
   end

   // ==========================================================
   // Read data, loaded in the waiting cycle so it stands when waitrequest drops
   always_comb begin
      rdata_d = rdata_q;
      if (i_avs_read && wait_q) begin
         rdata_d = '0;
         unique case (i_avs_address)
            cpl_pkg::ADDR_PORT0_DATA: rdata_d[7:0] = p0_level;
            cpl_pkg::ADDR_PORT1_DATA: rdata_d[7:0] = p1_level;
            cpl_pkg::ADDR_PORT0_RMW: rdata_d[7:0] = p0_latch_q;
            cpl_pkg::ADDR_PORT1_RMW: rdata_d[7:0] = p1_latch_q;
            cpl_pkg::ADDR_ROUTE3: rdata_d[7:0] = route3_q;
            cpl_pkg::ADDR_PORT0_STYLE: rdata_d[7:0] = p0_style_q;
            cpl_pkg::ADDR_PORT1_STYLE: rdata_d[7:0] = p1_style_q;
            cpl_pkg::ADDR_PORT1_INSTYLE: rdata_d[7:0] = p1_instyle_q;
            default: rdata_d = '0; // Unmapped reads return zero
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ==========================================================
   // Routing: output functions claim their pin, input functions tap one
   always_comb begin
      p0_claim = '0;
      p0_claim_val = '0;
      p0_claim_pp = '0;
      p1_claim = '0;
      p1_claim_val = '0;
      p1_claim_pp = '0;
      if (i_can_tx_route) begin
         p0_claim = pin_mask(CAN_TX_PIN);
         p0_claim_val = {8{i_can_transmit_pin}} & pin_mask(CAN_TX_PIN);
         if (route3_q[cpl_pkg::BIT_CAN_TX_DRIVE_STYLE]) begin
            p0_claim_pp = pin_mask(CAN_TX_PIN);
         end
      end
      // Analog pins are never claimed, so they keep the latch drive
      if (route3_q[cpl_pkg::BIT_COMPARATOR2_ROUTE] &&
          |(p1_instyle_q & pin_mask(CMP2_PIN))) begin
         p1_claim = pin_mask(CMP2_PIN);
         p1_claim_val = {8{i_comparator2_output}} & pin_mask(CMP2_PIN);
         p1_claim_pp = p1_style_q & pin_mask(CMP2_PIN);
      end
      // Unrouted inputs rest at zero so the peripheral sees no edges
      conv2_d = route3_q[cpl_pkg::BIT_CONV2_START_ROUTE] && |(p1_level & pin_mask(CONV2_START_PIN));
      t3cap_d = route3_q[cpl_pkg::BIT_TIMER3_CAPTURE_ROUTE] && |(p1_level & pin_mask(T3_CAPTURE_PIN));
      t3cnt_d = route3_q[cpl_pkg::BIT_TIMER3_COUNT_ROUTE] && |(p1_level & pin_mask(T3_COUNT_PIN));
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         conv2_q <= 1'b0;
         t3cap_q <= 1'b0;
         t3cnt_q <= 1'b0;
      end else begin
         conv2_q <= conv2_d;
         t3cap_q <= t3cap_d;
         t3cnt_q <= t3cnt_d;
      end
   end

   // ==========================================================
   // Pads
   cpl_pin_cell #(.WIDTH(8)) u_port0 (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_latch(p0_latch_q),
      .i_push_pull(p0_style_q),
      .i_claim(p0_claim),
      .i_claim_value(p0_claim_val),
      .i_claim_push_pull(p0_claim_pp),
      .i_digital_en(8'hff),
      .i_pad_in(i_p0_pad),
      .o_pad_out(o_p0_pad_out),
      .o_pad_oe(o_p0_pad_oe),
      .o_level(p0_level)
   );

   // Input style bit 0 marks an analog pin: digital input forced low
   cpl_pin_cell #(.WIDTH(8)) u_port1 (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_latch(p1_latch_q),
      .i_push_pull(p1_style_q),
      .i_claim(p1_claim),
      .i_claim_value(p1_claim_val),
      .i_claim_push_pull(p1_claim_pp),
      .i_digital_en(p1_instyle_q),
      .i_pad_in(i_p1_pad),
      .o_pad_out(o_p1_pad_out),
      .o_pad_oe(o_p1_pad_oe),
      .o_level(p1_level)
   );

   assign o_avs_readdata = rdata_q;
   assign o_avs_waitrequest = wait_q;
   assign o_conv2_external_start = conv2_q;
   assign o_timer3_capture_input = t3cap_q;
   assign o_timer3_count_input = t3cnt_q;
endmodule : cpl_top

// ===== core/cpl_pkg.sv
// Overview of operation
// - Routing bit 7 picks the CAN transmit pin drive: 0 open-drain, 1 push-pull.
// - Routing bit 3 puts the comparator 2 output on its pin if that pin is digital, else nowhere.
// - Routing bit 2 feeds a pin to the converter 2 external start, else none.
// - Routing bit 1 feeds a pin to the timer 3 capture input, else none.
// - Routing bit 0 feeds a pin to the timer 3 count input, else none.
// - Latch bits appear on pins not claimed by a routed function, one per pin.
// - A latch bit of zero drives its pin low in either output mode.
// - A latch bit of one drives high if push-pull, else leaves the pin undriven.
// - Reading a port data register returns the pin levels, whatever the routing, but zero for port 1 analog pins.
// - The read-modify-write read returns the latch contents instead of pin levels.
// - After reset every pin output mode is open-drain.
package cpl_pkg;
   // ==========================================================
   // Register byte addresses
   localparam logic [7:0] ADDR_PORT0_DATA = 8'h80;
   localparam logic [7:0] ADDR_PORT1_DATA = 8'h90;
   localparam logic [7:0] ADDR_ROUTE3 = 8'ha0;
   localparam logic [7:0] ADDR_PORT0_STYLE = 8'ha4;
   localparam logic [7:0] ADDR_PORT1_STYLE = 8'ha8;
   localparam logic [7:0] ADDR_PORT1_INSTYLE = 8'hac;
   localparam logic [7:0] ADDR_PORT0_RMW = 8'hc0;
   localparam logic [7:0] ADDR_PORT1_RMW = 8'hd0;
   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_PORT_LATCH = 8'hff;
   localparam logic [7:0] RST_ROUTE3 = 8'h00;
   localparam logic [7:0] RST_OUT_STYLE = 8'h00;
   localparam logic [7:0] RST_IN_STYLE = 8'hff;
   // ==========================================================
   // Field positions of the third routing register
   localparam int BIT_CAN_TX_DRIVE_STYLE = 7;
   localparam int BIT_COMPARATOR2_ROUTE = 3;
   localparam int BIT_CONV2_START_ROUTE = 2;
   localparam int BIT_TIMER3_CAPTURE_ROUTE = 1;
   localparam int BIT_TIMER3_COUNT_ROUTE = 0;
   localparam logic [7:0] ROUTE3_WRITE_MASK = 8'h8f;
   // ==========================================================
   // Pad drive for one port
   typedef struct packed {
      logic [7:0] value;
      logic [7:0] oe;
   } cpl_pad_s;
endpackage : cpl_pkg

// ===== core/cpl_pin_cell.sv
`timescale 1ns/10ps
// ==========================================================
// One 8-pin port: pad drivers and input synchroniser
module cpl_pin_cell #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Drive settings
   input wire logic [WIDTH-1:0] i_latch,
   input wire logic [WIDTH-1:0] i_push_pull,
   input wire logic [WIDTH-1:0] i_claim,
   input wire logic [WIDTH-1:0] i_claim_value,
   input wire logic [WIDTH-1:0] i_claim_push_pull,
   input wire logic [WIDTH-1:0] i_digital_en,
   // Pads
   input wire logic [WIDTH-1:0] i_pad_in,
   output logic [WIDTH-1:0] o_pad_out,
   output logic [WIDTH-1:0] o_pad_oe,
   // Synchronised levels
   output logic [WIDTH-1:0] o_level
);
   logic [WIDTH-1:0] out_q, out_d, oe_q, oe_d;
   logic [WIDTH-1:0] meta_q, level_q, level_d;
   logic [WIDTH-1:0] val;
   logic [WIDTH-1:0] pp;

   // Drive: a low value always drives, a high value only in push-pull
   always_comb begin
      val = (i_claim & i_claim_value) | (~i_claim & i_latch);
      pp = (i_claim & i_claim_push_pull) | (~i_claim & i_push_pull);
      out_d = val & pp;
      oe_d = ~val | pp;
      // No gating between the two stages, so the first stage feeds only the second
      level_d = meta_q;
   end

   // Pads undriven at reset since reset clears oe; latch high and mode open-drain keep it clear after
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         out_q <= '0;
         oe_q <= '0;
         meta_q <= '0;
         level_q <= '0;
      end else begin
         out_q <= out_d;
         oe_q <= oe_d;
         meta_q <= i_pad_in;
         level_q <= level_d;
      end
   end

   assign o_pad_out = out_q;
   assign o_pad_oe = oe_q;
   assign o_level = level_q & i_digital_en;
endmodule : cpl_pin_cell

// ===== tb/cpl_props.sv
`timescale 1ns/10ps
// ==========================================================
// Port checker
module cpl_props #(
   parameter int CAN_TX_PIN = 0,
   parameter int CONV2_START_PIN = 1
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Bus
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   // Peripherals and pads
   input wire logic i_can_tx_route,
   input wire logic o_conv2_external_start,
   input wire logic o_timer3_capture_input,
   input wire logic o_timer3_count_input,
   input wire logic [7:0] o_p0_pad_out,
   input wire logic [7:0] o_p0_pad_oe,
   input wire logic [7:0] o_p1_pad_out,
   input wire logic [7:0] o_p1_pad_oe
);
   logic [7:0] route_q;
   logic [7:0] route_d;
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   // Shadow of the routing register, taken at the accepting edge only
   always_comb begin
      route_d = route_q;
      if (i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0] &&
          i_avs_address == cpl_pkg::ADDR_ROUTE3) begin
         route_d = i_avs_writedata[7:0];
      end
   end
   always_ff @(posedge i_core_clk) begin
      route_q <= i_rst ? 8'h00 : route_d;
   end
   // ==========================================================
   // Properties
   AST_WAIT_ANSWER: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
      |=> !o_avs_waitrequest) else $error("waitrequest did not drop");
   AST_WAIT_ONE: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low too long");
   AST_READ_UPPER: assert property (o_avs_readdata[31:8] == 24'h000000)
      else $error("readdata upper bits set");
   AST_OD_HIGH: assert property (((o_p0_pad_out & ~o_p0_pad_oe) |
      (o_p1_pad_out & ~o_p1_pad_oe)) == 8'h00) else $error("undriven pad shows high");
   AST_RESET_OD: assert property ($fell(i_rst) |->
      (o_p0_pad_oe | o_p1_pad_oe) == 8'h00) else $error("pad driven after reset");
   AST_CNT_OFF: assert property (!route_q[0] && !$past(route_q[0])
      |-> !o_timer3_count_input) else $error("count input without route");
   AST_CAP_OFF: assert property (!route_q[1] && !$past(route_q[1])
      |-> !o_timer3_capture_input) else $error("capture input without route");
   AST_CONV_OFF: assert property (!route_q[2] && !$past(route_q[2])
      |-> !o_conv2_external_start) else $error("start input without route");
   AST_CAN_OD: assert property (i_can_tx_route && $past(i_can_tx_route) && !route_q[7]
      && !$past(route_q[7]) |-> !o_p0_pad_out[CAN_TX_PIN]) else $error("open-drain pin high");
   // Main scenarios reached
   cover property (i_avs_write && !o_avs_waitrequest);
   cover property (i_avs_read && !o_avs_waitrequest);
   cover property (route_q[0] && o_timer3_count_input);
endmodule : cpl_props

bind cpl_top cpl_props #(.CAN_TX_PIN(CAN_TX_PIN), .CONV2_START_PIN(CONV2_START_PIN)) i_cpl_props (
   .i_core_clk(i_core_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
   .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest), .i_can_tx_route(i_can_tx_route),
   .o_conv2_external_start(o_conv2_external_start),
   .o_timer3_capture_input(o_timer3_capture_input),
   .o_timer3_count_input(o_timer3_count_input), .o_p0_pad_out(o_p0_pad_out),
   .o_p0_pad_oe(o_p0_pad_oe), .o_p1_pad_out(o_p1_pad_out), .o_p1_pad_oe(o_p1_pad_oe));

// ===== tb/cpl_pad_model.sv
`timescale 1ns/10ps
// ==========================================================
// Board side of one port: pull-up or outside driver on released pins
module cpl_pad_model (
   // Pad drive from the block
   input wire cpl_pkg::cpl_pad_s i_pad,
   // Level the board puts on released pins
   input wire logic [7:0] i_ext,
   // Resolved pin levels
   output logic [7:0] o_level
);
   // A driven pin wins; a released pin never keeps the last driven value
   assign o_level = (i_pad.oe & i_pad.value) | (~i_pad.oe & i_ext);
endmodule : cpl_pad_model

// ===== tb/crossbar_port_latch_routing_bench.sv
`timescale 1ns/10ps
module crossbar_port_latch_routing_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] addr = 8'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] be = 4'hf;
   logic can_route = 1'b0;
   logic can_tx = 1'b0;
   logic cmp2 = 1'b0;
   logic [7:0] ext0 = 8'hff;
   logic [7:0] ext1 = 8'hff;
   logic [31:0] rdata;
   logic waitreq, conv2, t3cap, t3cnt;
   logic [7:0] p0_lvl, p1_lvl, p0_out, p0_oe, p1_out, p1_oe;
   int err_count = 0;
   int checks = 0;
   // ==========================================================
   // Design and board
   cpl_top i_cpl_top (.i_core_clk(clk), .i_rst(rst), .i_avs_address(addr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
      .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_can_tx_route(can_route),
      .i_can_transmit_pin(can_tx), .i_comparator2_output(cmp2),
      .o_conv2_external_start(conv2), .o_timer3_capture_input(t3cap),
      .o_timer3_count_input(t3cnt), .i_p0_pad(p0_lvl), .o_p0_pad_out(p0_out),
      .o_p0_pad_oe(p0_oe), .i_p1_pad(p1_lvl), .o_p1_pad_out(p1_out), .o_p1_pad_oe(p1_oe));
   cpl_pad_model i_p0_model (.i_pad({p0_out, p0_oe}), .i_ext(ext0), .o_level(p0_lvl));
   cpl_pad_model i_p1_model (.i_pad({p1_out, p1_oe}), .i_ext(ext1), .o_level(p1_lvl));
   // 50 ns period
   initial begin
      forever #25 clk = ~clk;
   end
   // ==========================================================
   // Bus and compare tasks; requests held until waitrequest is seen low
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
      addr <= a;
      wdata <= {24'h0, d};
      wr <= w;
      rd <= ~w;
      // Only the watchdog ends a wait that never sees waitrequest low
      do begin
         @(posedge clk);
      end while (waitreq !== 1'b0);
      q = rdata[7:0];
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // ==========================================================
   // Scenarios
   task automatic t_reset;
      logic [7:0] d;
      bus(1'b0, cpl_pkg::ADDR_ROUTE3, 8'h00, d);
      chk(d, cpl_pkg::RST_ROUTE3);
      bus(1'b0, cpl_pkg::ADDR_PORT0_RMW, 8'h00, d);
      chk(d, cpl_pkg::RST_PORT_LATCH);
      chk(p0_oe | p1_oe, 8'h00);
      bus(1'b0, 8'hf0, 8'h00, d);
      chk(d, 8'h00);
      $display("t_reset done");
   endtask : t_reset
   task automatic t_latch;
      logic [7:0] d;
      bus(1'b1, cpl_pkg::ADDR_PORT1_STYLE, 8'h0f, d);
      bus(1'b1, cpl_pkg::ADDR_PORT1_DATA, 8'h5a, d);
      ext1 <= 8'h00;
      repeat (4) @(posedge clk);
      chk(p1_out, 8'h0a);
      chk(p1_oe, 8'haf);
      bus(1'b0, cpl_pkg::ADDR_PORT1_DATA, 8'h00, d);
      chk(d, 8'h0a);
      be <= 4'he;
      bus(1'b1, cpl_pkg::ADDR_PORT1_DATA, 8'h00, d);
      be <= 4'hf;
      bus(1'b0, cpl_pkg::ADDR_PORT1_RMW, 8'h00, d);
      chk(d, 8'h5a);
      bus(1'b1, cpl_pkg::ADDR_PORT1_STYLE, 8'h00, d);
      bus(1'b1, cpl_pkg::ADDR_PORT1_DATA, 8'hff, d);
      ext1 <= 8'hff;
      $display("t_latch done");
   endtask : t_latch
   task automatic t_route;
      logic [7:0] d;
      cmp2 <= 1'b1;
      bus(1'b1, cpl_pkg::ADDR_ROUTE3, 8'hff, d);
      bus(1'b0, cpl_pkg::ADDR_ROUTE3, 8'h00, d);
      chk(d, 8'h8f);
      repeat (4) @(posedge clk);
      chk({5'h00, conv2, t3cap, t3cnt}, 8'h07);
      ext1 <= 8'hf5;
      repeat (4) @(posedge clk);
      chk({5'h00, conv2, t3cap, t3cnt}, 8'h02);
      bus(1'b1, cpl_pkg::ADDR_ROUTE3, 8'h00, d);
      ext1 <= 8'hff;
      repeat (4) @(posedge clk);
      chk({5'h00, conv2, t3cap, t3cnt}, 8'h00);
      $display("t_route done");
   endtask : t_route
   task automatic t_port0;
      logic [7:0] d;
      bus(1'b1, cpl_pkg::ADDR_PORT0_STYLE, 8'hf0, d);
      bus(1'b1, cpl_pkg::ADDR_PORT0_DATA, 8'h3c, d);
      ext0 <= 8'h00;
      repeat (4) @(posedge clk);
      chk(p0_out, 8'h30);
      chk(p0_oe, 8'hf3);
      bus(1'b0, cpl_pkg::ADDR_PORT0_DATA, 8'h00, d);
      chk(d, 8'h30);
      bus(1'b1, cpl_pkg::ADDR_PORT0_STYLE, 8'h00, d);
      bus(1'b1, cpl_pkg::ADDR_PORT0_DATA, 8'hff, d);
      ext0 <= 8'hff;
      $display("t_port0 done");
   endtask : t_port0
   task automatic t_cmp2;
      logic [7:0] d;
      cmp2 <= 1'b0;
      bus(1'b1, cpl_pkg::ADDR_ROUTE3, 8'h08, d);
      repeat (4) @(posedge clk);
      chk({6'h00, p1_oe[0], p1_out[0]}, 8'h02);
      bus(1'b1, cpl_pkg::ADDR_PORT1_INSTYLE, 8'hfe, d);
      repeat (4) @(posedge clk);
      chk({6'h00, p1_oe[0], p1_out[0]}, 8'h00);
      bus(1'b0, cpl_pkg::ADDR_PORT1_DATA, 8'h00, d);
      chk(d, 8'hfe);
      bus(1'b1, cpl_pkg::ADDR_PORT1_INSTYLE, 8'hff, d);
      bus(1'b1, cpl_pkg::ADDR_ROUTE3, 8'h00, d);
      repeat (4) @(posedge clk);
      chk({6'h00, p1_oe[0], p1_out[0]}, 8'h00);
      $display("t_cmp2 done");
   endtask : t_cmp2
   task automatic t_can;
      logic [7:0] d;
      can_route <= 1'b1;
      can_tx <= 1'b1;
      bus(1'b1, cpl_pkg::ADDR_ROUTE3, 8'h80, d);
      repeat (4) @(posedge clk);
      chk({6'h00, p0_oe[0], p0_out[0]}, 8'h03);
      bus(1'b1, cpl_pkg::ADDR_ROUTE3, 8'h00, d);
      repeat (4) @(posedge clk);
      chk({6'h00, p0_oe[0], p0_out[0]}, 8'h00);
      can_route <= 1'b0;
      $display("t_can done");
   endtask : t_can
   // ==========================================================
   // Verdict
   task automatic test_done;
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : test_done
   // Main sequence after three reset cycles
   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_latch();
      t_route();
      t_port0();
      t_cmp2();
      t_can();
      test_done();
   end
   // Watchdog, well past the hundred or so cycles the tests need
   initial begin
      #100000;
      err_count++;
      test_done();
   end
endmodule : crossbar_port_latch_routing_bench
